// ### rtl/dptio_pkg.sv
// Constants and types for the debug probe trigger input/output unit
// Function
// - Two independent trigger input channels
// - Two independent trigger output channels
// - Input edge detect: rising, falling, both
// - Input level detect: low or high
// - Met condition with break action requests break
// - Record current samples only during level
// - Output source: break or current trigger
// - Break pulse, polarity set, 1-65535 us
// - Current trigger pulse high, 1-65535 us
// - Level mode: high while condition holds
// - Break reaches halt in about 100 us
package dptio_pkg;

	// ------------------------------------------------------------
	// Channels and timing
	// ------------------------------------------------------------
	localparam int unsigned NUM_CH       = 2;
	localparam int unsigned CLK_MHZ      = 200;
	localparam int unsigned STEP_US      = 1;
	localparam int unsigned STEP_CYC     = STEP_US * CLK_MHZ;
	localparam int unsigned WIDTH_BITS   = 16;
	localparam int unsigned BRK_LAT_US   = 100;
	localparam int unsigned BRK_LAT_CYC  = BRK_LAT_US * CLK_MHZ;

	// ------------------------------------------------------------
	// Detection modes (3-bit field per input)
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DPTIO_DET_OFF     = 3'h0,
		DPTIO_DET_RISE    = 3'h1,
		DPTIO_DET_FALL    = 3'h2,
		DPTIO_DET_BOTH    = 3'h3,
		DPTIO_DET_LVL_LO  = 3'h4,
		DPTIO_DET_LVL_HI  = 3'h5
	} dptio_det_t;

	// Output sources and modes
	localparam logic SRC_BREAK = 1'b0;
	localparam logic SRC_CUR   = 1'b1;
	localparam logic MODE_PULSE = 1'b0;
	localparam logic MODE_LEVEL = 1'b1;

	localparam logic [15:0] WIDTH_RST = 16'h0001;

endpackage : dptio_pkg

// ### rtl/dptio_pulse_gen.sv
// Programmable one-shot pulse timer in microsecond steps
module dptio_pulse_gen #(
	parameter int unsigned STEP_CYC = dptio_pkg::STEP_CYC,
	parameter int unsigned WBITS    = dptio_pkg::WIDTH_BITS
) (
	input  wire logic             core_clk_i, // Clock
	input  wire logic             rst_n_i,    // Sync reset, active low
	input  wire logic             start_i,    // Start pulse
	input  wire logic [WBITS-1:0] width_i,    // Width in us, 0 as 1
	output logic                  busy_o      // High while pulse runs
);
	localparam int unsigned PB = $clog2(STEP_CYC + 1);

	logic [PB-1:0]    pre_r;
	logic [WBITS-1:0] us_r;
	logic             busy_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			busy_r <= 1'b0;
			pre_r  <= '0;
			us_r   <= '0;
		end else if (start_i && !busy_r) begin
			busy_r <= 1'b1;
			pre_r  <= PB'(STEP_CYC - 1);
			us_r   <= (width_i == '0) ? WBITS'(1) : width_i;
		end else if (busy_r) begin
			if (pre_r != '0) begin
				pre_r <= pre_r - PB'(1);
			end else begin
				pre_r <= PB'(STEP_CYC - 1);
				us_r  <= us_r - WBITS'(1);
				if (us_r == WBITS'(1)) begin
					busy_r <= 1'b0;
				end
			end
		end
	end

	assign busy_o = busy_r;

endmodule : dptio_pulse_gen

// ### rtl/dptio_trig_io.sv
// Trigger input detection and trigger output generation, two channels
module dptio_trig_io #(
	parameter int unsigned NUM_CH   = dptio_pkg::NUM_CH,
	parameter int unsigned STEP_CYC = dptio_pkg::STEP_CYC
) (
	input  wire logic              core_clk_i,   // Clock, 200 MHz
	input  wire logic              rst_n_i,      // Sync reset, active low
	input  wire logic [NUM_CH-1:0] trig_in_i,    // Trigger input pins
	input  wire logic [3*NUM_CH-1:0] in_det_i,   // Detect mode per input
	input  wire logic [NUM_CH-1:0] in_brk_en_i,  // Input acts as break
	input  wire logic [NUM_CH-1:0] in_cur_en_i,  // Input gates recording
	input  wire logic              brk_det_i,    // Break detected pulse
	input  wire logic              cur_trig_i,   // Current cond. level
	input  wire logic [NUM_CH-1:0] out_src_i,    // 0 break, 1 current
	input  wire logic [NUM_CH-1:0] out_mode_i,   // 0 pulse, 1 level
	input  wire logic [NUM_CH-1:0] out_pol_hi_i, // Break pulse polarity
	input  wire logic [16*NUM_CH-1:0] out_width_i, // Pulse width in us
	output logic                   brk_req_o,    // Break request pulse
	output logic                   cur_rec_en_o, // Record samples
	output logic [NUM_CH-1:0]      in_match_o,   // Input cond. met
	output logic [NUM_CH-1:0]      trig_out_o    // Trigger output pins
);

	// ------------------------------------------------------------
	// Input side
	// ------------------------------------------------------------
	logic [NUM_CH-1:0] sync1_r;
	logic [NUM_CH-1:0] sync2_r;
	logic [NUM_CH-1:0] prev_r;
	logic [NUM_CH-1:0] hit;
	logic [NUM_CH-1:0] lvl_hit;
	logic [NUM_CH-1:0] brk_hit;
	logic              cur_d_r;
	logic              brk_req_r;
	logic              cur_rec_r;
	logic [NUM_CH-1:0] out_r;

	// Sync stage one is read only by stage two
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= trig_in_i;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_in
			dptio_pkg::dptio_det_t det;
			logic rise;
			logic fall;
			assign det  = dptio_pkg::dptio_det_t'(in_det_i[3*g +: 3]);
			assign rise = sync2_r[g] & ~prev_r[g];
			assign fall = ~sync2_r[g] & prev_r[g];
			always_comb begin
				hit[g]     = 1'b0;
				lvl_hit[g] = 1'b0;
				case (det)
					dptio_pkg::DPTIO_DET_RISE:   hit[g] = rise;
					dptio_pkg::DPTIO_DET_FALL:   hit[g] = fall;
					dptio_pkg::DPTIO_DET_BOTH:   hit[g] = rise | fall;
					dptio_pkg::DPTIO_DET_LVL_LO: begin
						hit[g]     = ~sync2_r[g];
						lvl_hit[g] = ~sync2_r[g];
					end
					dptio_pkg::DPTIO_DET_LVL_HI: begin
						hit[g]     = sync2_r[g];
						lvl_hit[g] = sync2_r[g];
					end
					default: begin
						hit[g]     = 1'b0;
						lvl_hit[g] = 1'b0;
					end
				endcase
			end
			// A held level requests a break once, on its first cycle
			assign brk_hit[g] = in_brk_en_i[g] &
				(lvl_hit[g] ? ~(det == dptio_pkg::DPTIO_DET_LVL_HI
					? prev_r[g] : ~prev_r[g]) : hit[g]);
		end
	endgenerate

	assign in_match_o = hit;

	// Halt latency is the debugger's; request is one cycle only
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			brk_req_r <= 1'b0;
		end else begin
			brk_req_r <= |brk_hit;
		end
	end

	// Recording only while the selected level persists
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur_rec_r <= 1'b0;
		end else begin
			cur_rec_r <= |(lvl_hit & in_cur_en_i);
		end
	end

	assign brk_req_o    = brk_req_r;
	assign cur_rec_en_o = cur_rec_r;

	// ------------------------------------------------------------
	// Output side
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cur_d_r <= 1'b0;
		end else begin
			cur_d_r <= cur_trig_i;
		end
	end

	generate
		for (g = 0; g < NUM_CH; g++) begin : g_out
			logic start;
			logic busy;
			logic nxt;
			assign start = (out_src_i[g] == dptio_pkg::SRC_BREAK)
				? brk_det_i : (cur_trig_i & ~cur_d_r);
			dptio_pulse_gen #(
				.STEP_CYC (STEP_CYC),
				.WBITS    (dptio_pkg::WIDTH_BITS)
			) u_pulse (
				.core_clk_i (core_clk_i),
				.rst_n_i    (rst_n_i),
				.start_i    (start),
				.width_i    (out_width_i[16*g +: 16]),
				.busy_o     (busy)
			);
			always_comb begin
				if (out_src_i[g] == dptio_pkg::SRC_BREAK) begin
					nxt = out_pol_hi_i[g] ? busy : ~busy;
				end else if (out_mode_i[g] == dptio_pkg::MODE_LEVEL) begin
					nxt = cur_trig_i;
				end else begin
					nxt = busy;
				end
			end
			// Idle level follows the selected polarity after reset
			always_ff @(posedge core_clk_i) begin
				if (!rst_n_i) begin
					out_r[g] <= 1'b0;
				end else begin
					out_r[g] <= nxt;
				end
			end
		end
	endgenerate

	assign trig_out_o = out_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_brk_edge_req: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_brk_en_i[0] && in_det_i[2:0] == 3'h1 && $rose(sync2_r[0]))
		|=> brk_req_o)
		else $error("Break not requested on rising edge");
	a_rise_only: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[2:0] == 3'h1 && $fell(sync2_r[0])) |-> !in_match_o[0])
		else $error("Rising mode matched a falling edge");
	a_fall_match: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[2:0] == 3'h2 && $fell(sync2_r[0])) |-> in_match_o[0])
		else $error("Falling edge not matched");
	a_level_low: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[2:0] == 3'h4) |-> (in_match_o[0] == !sync2_r[0]))
		else $error("Low level match wrong");
	a_rec_gate: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_cur_en_i == 2'b01 && $stable(in_det_i) && in_det_i[2:0] == 3'h5)
		##1 (in_cur_en_i == 2'b01 && $stable(in_det_i))
		|-> (cur_rec_en_o == $past(sync2_r[0])))
		else $error("Recording not gated by level");
	a_sync_delay: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		##2 (sync2_r == $past(trig_in_i, 2)))
		else $error("Input sync depth wrong");
	a_lvl_out: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(out_src_i[0] && out_mode_i[0] && $stable(out_src_i)
		&& $stable(out_mode_i)) |-> (trig_out_o[0] == $past(cur_trig_i)))
		else $error("Level output does not follow condition");
	a_brk_pulse_on: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(!out_src_i[0] && out_pol_hi_i[0] && brk_det_i
		&& !g_out[0].busy && $stable(out_src_i) && $stable(out_pol_hi_i))
		##1 ($stable(out_src_i) && $stable(out_pol_hi_i))
		|=> trig_out_o[0])
		else $error("Break pulse not started");
	a_cur_pulse: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(out_src_i[1] && !out_mode_i[1] && $rose(cur_trig_i)
		&& !g_out[1].busy && $stable(out_src_i) && $stable(out_mode_i))
		##1 ($stable(out_src_i) && $stable(out_mode_i))
		|=> trig_out_o[1])
		else $error("Current trigger pulse not started");

	// ------------------------------------------------------------
	// Other-channel mirrors, further checks and quiet cases
	// ------------------------------------------------------------
	a_rise_match1: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[5:3] == 3'h1
		&& $rose(sync2_r[1]))
		|-> in_match_o[1])
		else $error("Rising edge not matched on channel one");
	a_fall_only1: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[5:3] == 3'h2
		&& $rose(sync2_r[1]))
		|-> !in_match_o[1])
		else $error("Falling mode matched a rising edge");
	a_both_match: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[2:0] == 3'h3
		&& $changed(sync2_r[0]))
		|-> in_match_o[0])
		else $error("Both-edge mode missed a transition");
	a_off_quiet: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[2:0] == 3'h0)
		|-> !in_match_o[0])
		else $error("Disabled input reported a match");
	a_level_high: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_det_i[5:3] == 3'h5)
		|-> (in_match_o[1] == sync2_r[1]))
		else $error("High level match wrong");
	// A held level must not keep requesting breaks
	a_lvl_brk_once: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_brk_en_i == 2'b01 && in_det_i[2:0] == 3'h4
		&& !sync2_r[0] && !prev_r[0])
		|=> !brk_req_o)
		else $error("Held level requested a second break");
	a_no_brk_dis: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_brk_en_i == 2'b00)
		|=> !brk_req_o)
		else $error("Break requested with no input enabled");
	a_rec_off: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_cur_en_i == 2'b00)
		|=> !cur_rec_en_o)
		else $error("Recording with no input enabled");
	// Edge modes never gate recording, only levels do
	a_edge_no_rec: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(in_cur_en_i == 2'b01 && in_det_i[2:0] != 3'h4
		&& in_det_i[2:0] != 3'h5)
		|=> !cur_rec_en_o)
		else $error("Recording gated by an edge mode");
	a_brk_low_pulse: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(!out_src_i[1] && !out_pol_hi_i[1] && brk_det_i
		&& !g_out[1].busy && $stable(out_src_i)
		&& $stable(out_pol_hi_i))
		##1 ($stable(out_src_i) && $stable(out_pol_hi_i))
		|=> !trig_out_o[1])
		else $error("Low break pulse not started");
	a_brk_follow: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(!out_src_i[0] && out_pol_hi_i[0]
		&& $stable(out_src_i) && $stable(out_pol_hi_i))
		|-> (trig_out_o[0] == $past(g_out[0].busy)))
		else $error("Break output does not track its timer");
	a_lvl_out1: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(out_src_i[1] && out_mode_i[1]
		&& $stable(out_src_i) && $stable(out_mode_i))
		|-> (trig_out_o[1] == $past(cur_trig_i)))
		else $error("Channel one level output wrong");
	a_cur_pulse0: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		(out_src_i[0] && !out_mode_i[0] && $rose(cur_trig_i)
		&& !g_out[0].busy && $stable(out_src_i)
		&& $stable(out_mode_i))
		##1 ($stable(out_src_i) && $stable(out_mode_i))
		|=> trig_out_o[0])
		else $error("Channel zero current pulse not started");

	c_brk_req:  cover property (@(posedge core_clk_i) brk_req_o);
	c_rec:      cover property (@(posedge core_clk_i) cur_rec_en_o);
	c_out_puls: cover property (@(posedge core_clk_i)
		$rose(trig_out_o[0]) ##[1:400] $fell(trig_out_o[0]));
	c_both:     cover property (@(posedge core_clk_i) &in_match_o);
	c_pol_low:  cover property (@(posedge core_clk_i)
		$fell(trig_out_o[1]) ##[1:400] $rose(trig_out_o[1]));

endmodule : dptio_trig_io

// ### tb/dptio_ext_model.sv
// External instrument model driving the two trigger input pins
module dptio_ext_model (
	input  wire logic       clk_i,  // Bench clock
	input  wire logic [1:0] lvl_i,  // Levels the instrument asks for
	input  wire logic       slow_i, // One more cycle of delay
	output logic      [1:0] pin_o   // Trigger input pins
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] st1_r = 2'h0;
	logic [1:0] st2_r = 2'h0;
	// Pins are driven push-pull, so no released state exists
	always @(posedge clk_i) begin
		st1_r <= #1 lvl_i;
		st2_r <= #1 st1_r;
	end
	assign pin_o = slow_i ? st2_r : st1_r;
endmodule : dptio_ext_model

// ### tb/tb.sv
// Self-checking bench of the trigger input/output unit
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	n_mismatch++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam int SC = 2;
	logic        clk, rst_n, brk_det, cur_trig, slow, brk_req, rec_en;
	logic [1:0]  lvl, brk_en, cur_en, src, mode, pol, pin, match, tout;
	logic [5:0]  det;
	logic [31:0] width;
	logic [31:0] rnd = 32'h00004fe1;
	int          cyc, n_mismatch, samples_checked;
	int          exp_q[$];
	dptio_ext_model i_ext (.clk_i(clk), .lvl_i(lvl), .slow_i(slow),
		.pin_o(pin));
	dptio_trig_io #(.STEP_CYC(SC)) i_dut (.core_clk_i(clk), .rst_n_i(rst_n),
		.trig_in_i(pin), .in_det_i(det), .in_brk_en_i(brk_en),
		.in_cur_en_i(cur_en), .brk_det_i(brk_det), .cur_trig_i(cur_trig),
		.out_src_i(src), .out_mode_i(mode), .out_pol_hi_i(pol),
		.out_width_i(width), .brk_req_o(brk_req), .cur_rec_en_o(rec_en),
		.in_match_o(match), .trig_out_o(tout));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] next_rand();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction : next_rand
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	// Bounded wait for the pulse, then its length in cycles
	task automatic pulse_len(input int ch, input logic on, output int n);
		int t;
		for (t = 0; t < 20 && tout[ch] !== on; t++)
			step(1);
		if (t == 20) begin
			n_mismatch++;
			final_report();
		end
		for (n = 0; n < 300 && tout[ch] === on; n++)
			step(1);
	endtask : pulse_len
	// Level modes start from the inactive level, edges from a random one
	task automatic in_test(input int ch, input int m);
		logic        v;
		logic [31:0] r;
		int          i;
		r = next_rand();
		det = 6'h00;
		v = (m == 4) ? 1'b1 : (m == 5) ? 1'b0 : r[3];
		lvl[ch] = v;
		step(8);
		det[3*ch +: 3] = 3'(m);
		brk_en = 2'(1 << ch);
		cur_en = (m >= 4) ? brk_en : 2'h0;
		for (i = 0; i < 2; i++) begin
			r = next_rand();
			v = ~v;
			slow = r[0];
			lvl[ch] = v;
			lvl[1-ch] = r[1];
			if ((m == 1 && v) || (m == 2 && !v) || m == 3 ||
				(m == 4 && !v) || (m == 5 && v))
				exp_q.push_back(cyc + 4 + int'(r[0]));
			step(8);
			if (m >= 4) begin
				`CHK(match[ch], v ^ (m == 4))
				`CHK(rec_en, v ^ (m == 4))
			end
		end
		det = 6'h00;
	endtask : in_test
	// ------------------------------------------------------------
	// Clock, watcher, timeout
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	always @(negedge clk) begin
		if (rst_n === 1'b1 && brk_req === 1'b1) begin
			if (exp_q.size() == 0)
				`CHK(1'b1, 1'b0)
			else
				`CHK(cyc, exp_q.pop_front())
		end
	end
	initial begin
		#500000;
		n_mismatch++;
		final_report();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int          ch, m, w, wb, n;
		logic [31:0] r;
		rst_n = 1'b0;
		{brk_det, cur_trig, slow, lvl, det, brk_en, cur_en} = '0;
		{src, mode, pol, width} = '0;
		step(8);
		`CHK(tout, 2'h0)
		rst_n = 1'b1;
		step(2);
		`CHK(tout, 2'h3)
		for (ch = 0; ch < 2; ch++)
			for (m = 1; m < 6; m++)
				in_test(ch, m);
		`CHK(exp_q.size(), 0)
		$display("input detection done");
		for (ch = 0; ch < 2; ch++) begin
			for (m = 0; m < 2; m++) begin
				r = next_rand();
				w = r % 5;
				wb = (w == 0) ? 1 : w;
				pol[ch] = m[0];
				width[16*ch +: 16] = 16'(w);
				step(12);
				`CHK(tout[ch], ~m[0])
				brk_det = 1'b1;
				step(1);
				brk_det = 1'b0;
				// A second break inside the pulse must not stretch it
				fork
					pulse_len(ch, m[0], n);
					if (w >= 2) begin
						step(3);
						brk_det = 1'b1;
						step(1);
						brk_det = 1'b0;
					end
				join
				`CHK(n, wb * SC)
			end
			src[ch] = 1'b1;
			brk_det = 1'b1;
			step(1);
			brk_det = 1'b0;
			step(4);
			`CHK(tout[ch], 1'b0)
			for (m = 0; m < 2; m++) begin
				r = next_rand();
				mode[ch] = m[0];
				w = 3 + r % 6;
				cur_trig = 1'b1;
				fork
					pulse_len(ch, 1'b1, n);
					begin
						step(w);
						cur_trig = 1'b0;
					end
				join
				step(4);
				`CHK(n, m ? w : wb * SC)
			end
			$display("output channel %0d done", ch);
		end
		final_report();
	end
endmodule : tb
